// >>> common/ahp_pkg.sv
// constants, register map and types for the axis homing block
// Behaviour
// - seven homing sequences, numbered zero to six, each give a known position
// - slow phases use the slow rate, fast phases the fast rate, each settable
// - sequence zero copies measured position into demand, no motion
// - sequence zero clears flag bits 1,2,3,8,11 on every axis
// - sequence one runs positive slowly until the index marker, then zeroes
// - sequence two runs negative slowly until the index marker, then zeroes
// - sequence three: positive fast to switch, negative slow off it, zero
// - sequence four: negative fast to switch, positive slow off it, zero
// - sequence five: as three, then keeps negative to the marker, zero there
// - sequence six: as four, then keeps positive to the marker, zero there
// - zeroing clears demand and shifts measured alike, keeping following error
// - home switch is active low
// - positive limit, negative limit and feed hold are active low
// - position redefinition is accepted at any time, even while moving
// - redefinition values go to base axis, then next axes in turn
// - position adjustments take effect at the next servo tick only
// - redefinition becomes a pending offset reading zero once applied
// - continuous positive motion stops on stop, halt, positive or home limit
package ahp_pkg;
   localparam int POS_W = 32;
   localparam int FLAG_W = 12;
   localparam int SEQ_W = 3;
   localparam logic [SEQ_W-1:0] SEQ_LAST = 3'h6;
   // flag bits 1,2,3,8 and 11
   localparam logic [FLAG_W-1:0] FLAG_CLR_MASK = 12'h90E;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_SLOW = 8'h08;
   localparam logic [7:0] OFS_FAST = 8'h0C;
   localparam logic [7:0] OFS_BASE = 8'h10;
   localparam logic [7:0] OFS_DEFINE_POSITION_CMD = 8'h14;
   localparam logic [7:0] OFS_OFFSET = 8'h18;
   localparam logic [7:0] OFS_DEMAND = 8'h1C;
   localparam logic [7:0] OFS_MEAS = 8'h20;
   localparam logic [7:0] OFS_FLAGS = 8'h24;
   // control register fields
   localparam int CTRL_SEQ_LSB = 0;
   localparam int CTRL_START = 3;
   localparam int CTRL_FWD = 4;
   localparam int CTRL_STOP = 5;
   localparam int CTRL_HALT = 6;
   // reset values
   localparam logic [POS_W-1:0] SLOW_RST = 32'h0000_0001;
   localparam logic [POS_W-1:0] FAST_RST = 32'h0000_0010;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE, ST_FAST, ST_SLOW, ST_SEEK_Z, ST_CONT
   } ahp_state_e;
endpackage

// >>> hdl/ahp_axis_pos.sv
// one axis: demand, measured, pending offset and flag word
`timescale 1ns/100ps
module ahp_axis_pos
   import ahp_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // encoder and servo tick
   input wire logic servo_tick,
   input wire logic enc_step,
   input wire logic enc_dir,
   // requests from the homing logic
   input wire logic [POS_W-1:0] dem_delta,
   input wire logic zero_req,
   input wire logic copy_req,
   input wire logic offs_load,
   input wire logic [POS_W-1:0] offs_val,
   input wire logic [FLAG_W-1:0] flag_set,
   input wire logic [FLAG_W-1:0] flag_clr,
   // state
   output logic [POS_W-1:0] dem_reg,
   output logic [POS_W-1:0] meas_reg,
   output logic [POS_W-1:0] offs_reg,
   output logic [FLAG_W-1:0] flags_reg
);
   logic [POS_W-1:0] enc_inc;
   logic [POS_W-1:0] meas_cnt;
   logic apply;
   logic [POS_W-1:0] dem_next;
   logic [POS_W-1:0] meas_next;
   logic [POS_W-1:0] offs_next;

   // encoder count folded in every cycle
   assign enc_inc = !enc_step ? '0 : (enc_dir ? 32'h0000_0001 : 32'hFFFF_FFFF);
   assign meas_cnt = meas_reg + enc_inc;
   assign apply = servo_tick && (offs_reg != '0);

   // zero keeps the error: measured moves by what demand loses
   always_comb begin
      dem_next = servo_tick ? dem_reg + dem_delta : dem_reg;
      meas_next = meas_cnt;
      if (zero_req) begin
         dem_next = '0;
         meas_next = meas_cnt - dem_reg;
      end else if (copy_req) begin
         dem_next = meas_cnt;
      end else if (apply) begin
         dem_next = dem_next + offs_reg;
         meas_next = meas_cnt + offs_reg;
      end
   end

   // a fresh load wins over the apply so a new definition is never lost
   assign offs_next = offs_load ? offs_val : (apply ? '0 : offs_reg);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dem_reg <= '0;
         meas_reg <= '0;
         offs_reg <= '0;
         flags_reg <= '0;
      end else begin
         dem_reg <= dem_next;
         meas_reg <= meas_next;
         offs_reg <= offs_next;
         flags_reg <= (flags_reg & ~flag_clr) | flag_set; // set wins
      end
   end
endmodule

// >>> hdl/ahp_homing.sv
// homing sequencer, position redefinition and axi4-lite register slave
`timescale 1ns/100ps
module ahp_homing
   import ahp_pkg::*;
#(
   parameter int NUM_AXES = 4
)
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // servo timing and encoders
   input wire logic servo_tick,
   input wire logic [NUM_AXES-1:0] enc_step,
   input wire logic [NUM_AXES-1:0] enc_dir,
   input wire logic [NUM_AXES-1:0] enc_index,
   // switches, all active low
   input wire logic home_sw_n,
   input wire logic positive_limit_input_n,
   input wire logic negative_limit_input_n,
   input wire logic feed_hold_input_n,
   // flag events from the axes
   input wire logic [NUM_AXES*FLAG_W-1:0] axis_flag_set,
   // status out
   output logic [NUM_AXES*POS_W-1:0] axis_dem_pos,
   output logic homing_idle
);
   localparam int BASE_W = (NUM_AXES > 1) ? $clog2(NUM_AXES) : 1;

   // byte-lane merge, used by the slow, fast, base and define-position words
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // bus state
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   // software registers
   logic [POS_W-1:0] slow_reg;
   logic [POS_W-1:0] fast_reg;
   logic [BASE_W-1:0] base_reg;
   logic [BASE_W-1:0] def_idx_reg;
   logic [SEQ_W-1:0] seq_reg;
   logic dir_reg;
   logic idle_reg;
   ahp_state_e state_reg;
   ahp_state_e state_next;
   // per-axis views
   logic [POS_W-1:0] dem_a [NUM_AXES];
   logic [POS_W-1:0] meas_a [NUM_AXES];
   logic [POS_W-1:0] offs_a [NUM_AXES];
   logic [FLAG_W-1:0] flags_a [NUM_AXES];

   // write strobe fires once both address and data are held
   wire wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
   wire aw_take = s_axi_awvalid && awready_reg;
   wire w_take = s_axi_wvalid && wready_reg;
   wire ar_take = s_axi_arvalid && arready_reg;
   wire [31:0] wr_data = wdata_reg;
   wire wr_ctrl = wr_go && awaddr_reg == OFS_CTRL;
   wire wr_slow = wr_go && awaddr_reg == OFS_SLOW;
   wire wr_fast = wr_go && awaddr_reg == OFS_FAST;
   wire wr_base = wr_go && awaddr_reg == OFS_BASE;
   wire wr_def = wr_go && awaddr_reg == OFS_DEFINE_POSITION_CMD;
   wire wr_known = wr_ctrl || wr_slow || wr_fast || wr_base || wr_def;

   // control word commands; strobe lane 0 carries them
   wire ctl_ok = wr_ctrl && wstrb_reg[0];
   wire [SEQ_W-1:0] cmd_seq = wr_data[CTRL_SEQ_LSB +: SEQ_W];
   wire cmd_start = ctl_ok && wr_data[CTRL_START] && cmd_seq <= SEQ_LAST;
   wire cmd_fwd = ctl_ok && wr_data[CTRL_FWD];
   wire cmd_stop = ctl_ok && (wr_data[CTRL_STOP] || wr_data[CTRL_HALT]);

   // switch levels: a broken wire reads as active
   wire home_act = !home_sw_n;
   wire pos_lim = !positive_limit_input_n;
   wire neg_lim = !negative_limit_input_n;
   wire hold_act = !feed_hold_input_n;
   wire idx_seen = enc_index[base_reg];

   // motion of the base axis, one rate step per servo tick
   wire moving = state_reg != ST_IDLE;
   wire use_fast = state_reg == ST_FAST || state_reg == ST_CONT;
   wire [POS_W-1:0] rate = use_fast ? fast_reg : slow_reg;
   wire [POS_W-1:0] step = dir_reg ? rate : POS_W'(-rate);
   wire blocked = dir_reg ? pos_lim : neg_lim;
   wire [POS_W-1:0] base_delta = (moving && !hold_act) ? step : '0;

   // homing sequencer
   logic zero_now;
   always_comb begin
      state_next = state_reg;
      zero_now = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_start) begin
               case (cmd_seq)
                  3'h1, 3'h2: state_next = ST_SEEK_Z;
                  3'h3, 3'h4, 3'h5, 3'h6: state_next = ST_FAST;
                  default: state_next = ST_IDLE;
               endcase
            end else if (cmd_fwd) begin
               state_next = ST_CONT;
            end
         end
         ST_FAST: begin
            if (home_act) begin
               state_next = ST_SLOW;
            end
         end
         ST_SLOW: begin
            if (!home_act) begin
               if (seq_reg == 3'h5 || seq_reg == 3'h6) begin
                  state_next = ST_SEEK_Z;
               end else begin
                  zero_now = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_SEEK_Z: begin
            if (idx_seen) begin
               zero_now = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_CONT: begin
            if (pos_lim || home_act) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // stop, halt or a limit in the way of travel end any motion
      if (moving && (cmd_stop || blocked)) begin
         state_next = ST_IDLE;
         zero_now = 1'b0;
      end
   end

   // direction flips at the switch for the slow back-off
   logic dir_next;
   always_comb begin
      dir_next = dir_reg;
      if (state_reg == ST_IDLE && cmd_start) begin
         dir_next = cmd_seq[0]; // odd sequences start positive
      end else if (state_reg == ST_IDLE && cmd_fwd) begin
         dir_next = 1'b1;
      end else if (state_reg == ST_FAST && home_act) begin
         dir_next = !dir_reg;
      end
   end

   // sequence zero: copy on base axis, flag clear on all axes
   wire seq0 = state_reg == ST_IDLE && cmd_start && cmd_seq == 3'h0;
   wire [FLAG_W-1:0] clr_all = seq0 ? FLAG_CLR_MASK : '0;

   // redefinition targets base, then the next axes in turn; wraps for
   // power-of-two axis counts only
   wire [BASE_W-1:0] def_axis = base_reg + def_idx_reg;

   genvar g;
   generate
      for (g = 0; g < NUM_AXES; g++) begin : g_axis
         wire is_base = base_reg == BASE_W'(g);
         wire def_hit = wr_def && def_axis == BASE_W'(g);
         // offset is the jump from the present demand to the new value
         wire [POS_W-1:0] def_val = merge(dem_a[g], wr_data, wstrb_reg);
         ahp_axis_pos u_pos (
            .clock(clock),
            .arst_n(arst_n),
            .servo_tick(servo_tick),
            .enc_step(enc_step[g]),
            .enc_dir(enc_dir[g]),
            .dem_delta(is_base ? base_delta : '0),
            .zero_req(is_base && zero_now),
            .copy_req(is_base && seq0),
            .offs_load(def_hit),
            .offs_val(def_val - dem_a[g]),
            .flag_set(axis_flag_set[g*FLAG_W +: FLAG_W]),
            .flag_clr(clr_all),
            .dem_reg(dem_a[g]),
            .meas_reg(meas_a[g]),
            .offs_reg(offs_a[g]),
            .flags_reg(flags_a[g])
         );
         assign axis_dem_pos[g*POS_W +: POS_W] = dem_a[g];
      end
   endgenerate

   // read mux for the base axis and the block's own state
   wire [7:0] ra = s_axi_araddr;
   wire [31:0] stat_word = {24'h0, 3'(state_reg), hold_act, neg_lim,
                            pos_lim, home_act, idle_reg};
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      case (ra)
         OFS_CTRL: rd_mux = {29'h0, seq_reg};
         OFS_STAT: rd_mux = stat_word;
         OFS_SLOW: rd_mux = slow_reg;
         OFS_FAST: rd_mux = fast_reg;
         OFS_BASE: rd_mux = 32'(base_reg);
         OFS_DEFINE_POSITION_CMD: rd_mux = 32'h0;
         OFS_OFFSET: rd_mux = offs_a[base_reg];
         OFS_DEMAND: rd_mux = dem_a[base_reg];
         OFS_MEAS: rd_mux = meas_a[base_reg];
         OFS_FLAGS: rd_mux = 32'(flags_a[base_reg]);
         default: begin
            rd_mux = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end

   // write channel capture, each channel taken on its own
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_hold_reg <= 1'b0;
         end
         if (w_take) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   // ready lines and write response
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         awready_reg <= !aw_hold_reg && !aw_take && !bvalid_reg;
         wready_reg <= !w_hold_reg && !w_take && !bvalid_reg;
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // read channel: data registered at the address handshake
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= RESP_OKAY;
      end else begin
         arready_reg <= !rvalid_reg && !ar_take;
         if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // software settings and redefinition index
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         slow_reg <= SLOW_RST;
         fast_reg <= FAST_RST;
         base_reg <= '0;
         def_idx_reg <= '0;
         seq_reg <= '0;
      end else begin
         if (wr_slow) slow_reg <= merge(slow_reg, wr_data, wstrb_reg);
         if (wr_fast) fast_reg <= merge(fast_reg, wr_data, wstrb_reg);
         if (wr_base) begin
            base_reg <= BASE_W'(merge(32'(base_reg), wr_data, wstrb_reg));
            def_idx_reg <= '0;
         end else if (wr_def) begin
            def_idx_reg <= def_idx_reg + 1'b1;
         end
         if (cmd_start && state_reg == ST_IDLE) seq_reg <= cmd_seq;
      end
   end

   // sequencer state; idle shown only once zeroing is done
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         dir_reg <= 1'b1;
         idle_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         dir_reg <= dir_next;
         idle_reg <= state_next == ST_IDLE;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign homing_idle = idle_reg;
endmodule

// >>> sim/ahp_homing_properties.sv
// concurrent checks on the homing block ports, bound into its top
`timescale 1ns/100ps
module ahp_homing_properties
   import ahp_pkg::*;
#(
   parameter int NUM_AXES = 4
)
(
   // clock, reset and register bus
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // motion side
   input wire logic servo_tick,
   input wire logic [NUM_AXES-1:0] enc_index,
   input wire logic home_sw_n,
   input wire logic positive_limit_input_n,
   input wire logic feed_hold_input_n,
   input wire logic [NUM_AXES*POS_W-1:0] axis_dem_pos,
   input wire logic homing_idle
);
   logic [2:0] seq_q;
   logic sw_q;
   logic rel_q;
   wire run = !homing_idle;
   wire seq56 = seq_q == 3'h5 || seq_q == 3'h6;
   wire ctl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready && s_axi_awaddr == OFS_CTRL;
   wire [POS_W-1:0] dem0 = axis_dem_pos[POS_W-1:0];
   // last started sequence, 7 for continuous motion; rel_q marks release
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         seq_q <= 3'h7;
         sw_q <= 1'b1;
         rel_q <= 1'b0;
      end else begin
         sw_q <= home_sw_n;
         if (ctl_wr && (s_axi_wdata[3] || s_axi_wdata[4])) begin
            seq_q <= s_axi_wdata[4] ? 3'h7 : s_axi_wdata[2:0];
            rel_q <= 1'b0;
         end else if (seq56 && run && home_sw_n && !sw_q) begin
            rel_q <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   // zeroed demand, then idle one or two cycles later
   sequence s_zero_idle;
      dem0 == '0 ##[1:2] homing_idle;
   endsequence
   property p_r_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_b_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_index_zero;
      (seq_q == 3'h1 || seq_q == 3'h2) && run && enc_index[0] |=> s_zero_idle;
   endproperty
   a_index_zero: assert property (p_index_zero)
      else $error("no zeroing at index marker");
   property p_sw_release;
      (seq_q == 3'h3 || seq_q == 3'h4) && run && $rose(home_sw_n)
         |=> s_zero_idle;
   endproperty
   a_sw_release: assert property (p_sw_release)
      else $error("no zeroing at switch release");
   property p_seq56_keep;
      seq56 && run && $rose(home_sw_n) |=> !homing_idle;
   endproperty
   a_seq56_keep: assert property (p_seq56_keep)
      else $error("stopped at switch release");
   property p_seq56_index;
      rel_q && run && enc_index[0] |=> s_zero_idle;
   endproperty
   a_seq56_index: assert property (p_seq56_index)
      else $error("no zeroing at marker after release");
   property p_lim_stop;
      seq_q == 3'h7 && run && $fell(positive_limit_input_n)
         |-> ##[1:2] homing_idle;
   endproperty
   a_lim_stop: assert property (p_lim_stop)
      else $error("positive limit did not stop motion");
   property p_hold;
      seq_q == 3'h7 && run && !feed_hold_input_n && servo_tick
         |=> $stable(dem0);
   endproperty
   a_hold: assert property (p_hold)
      else $error("demand moved during feed hold");
endmodule
bind ahp_homing ahp_homing_properties #(.NUM_AXES(NUM_AXES)) chk (.*);

// >>> sim/ahp_motor_model.sv
// drive, encoder, index marker and home switch of axis 0
`timescale 1ns/100ps
module ahp_motor_model #(
   parameter int HOME_LO = 100,
   parameter int HOME_HI = 140
)
(
   // clock, reset and demand
   input wire logic clock,
   input wire logic arst_n,
   input wire logic servo_tick,
   input wire logic [31:0] dem,
   // encoder and switch
   output logic enc_step,
   output logic enc_dir,
   output logic enc_index,
   output logic home_sw_n
);
   int pos;
   int togo;
   int d;
   logic [31:0] dem_q;
   logic tick_q;
   // shaft follows each tick's demand step; big jumps are zeroing or
   // redefinition and leave the shaft where it is
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pos = 0;
         togo = 0;
         tick_q <= 1'b0;
         dem_q <= 32'h0;
         {enc_step, enc_dir, enc_index, home_sw_n} <= 4'h5;
      end else begin
         tick_q <= servo_tick;
         if (servo_tick) dem_q <= dem;
         d = int'(dem - dem_q);
         if (tick_q && d > -64 && d < 64) togo = togo + d;
         enc_step <= 1'b0;
         enc_index <= 1'b0;
         if (togo != 0 && !enc_step) begin
            d = togo > 0 ? 1 : -1;
            pos = pos + d;
            togo = togo - d;
            enc_step <= 1'b1;
            enc_dir <= d > 0;
            enc_index <= pos % 32 == 0;
         end
         // two switch zones, either side of zero; low while inside
         home_sw_n <= !((pos >= HOME_LO && pos <= HOME_HI) ||
            (pos <= -HOME_LO && pos >= -HOME_HI));
      end
   end
endmodule

// >>> sim/ahp_homing_tb.sv
// self-checking bench for the axis homing block
`timescale 1ns/100ps
module ahp_homing_tb;
   import ahp_pkg::*;
   localparam int N = 4;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic servo_tick = 1'b0;
   logic [N-1:1] bstep = '0;
   wire [N-1:0] enc_step, enc_dir, enc_index;
   logic m_step, m_dir, m_idx, home_sw_n;
   logic positive_limit_input_n = 1'b1, feed_hold_input_n = 1'b1;
   logic [N*FLAG_W-1:0] axis_flag_set = '0;
   logic [N*POS_W-1:0] axis_dem_pos;
   logic homing_idle;
   int failures = 0, comparisons = 0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [31:0] rnd = 32'h6041, f, k, v0, v1;
   logic [2:0] hs[6] = '{3'h3, 3'h5, 3'h4, 3'h6, 3'h1, 3'h2};
   // axis 0 encoder from the drive model, the rest from the bench
   assign enc_step = {bstep, m_step};
   assign enc_dir = {{(N-1){1'b1}}, m_dir};
   assign enc_index = {{(N-1){1'b0}}, m_idx};
   ahp_homing #(.NUM_AXES(N)) uut (.*, .negative_limit_input_n(1'b1));
   ahp_motor_model mdl (
      .clock, .arst_n, .servo_tick, .dem(axis_dem_pos[POS_W-1:0]),
      .enc_step(m_step), .enc_dir(m_dir), .enc_index(m_idx), .home_sw_n
   );
   always #20 clock = ~clock;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task check(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task give_verdict();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // both channels offered together, each released when taken
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic aw, w;
      bq.push_back(e);
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (aw || w) begin
         @(posedge clock);
         if (aw && s_axi_awready) {aw, s_axi_awvalid} <= 2'b00;
         if (w && s_axi_wready) {w, s_axi_wvalid} <= 2'b00;
         #1;
      end
      do @(posedge clock); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask
   task rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask
   task tick();
      servo_tick <= 1'b1;
      @(posedge clock);
      servo_tick <= 1'b0;
      repeat (39) @(posedge clock);
   endtask
   // start a sequence, tick until idle, expect demand zero
   task home(input logic [2:0] s);
      int i;
      wr(OFS_CTRL, {28'h0, 1'b1, s}, RESP_OKAY);
      for (i = 0; i < 300 && !(i > 0 && homing_idle === 1'b1); i++) tick();
      check({33'h0, homing_idle}, 34'h1);
      rd(OFS_DEMAND, 34'h0);
   endtask
   // bus answers are compared with the oldest note in their queue
   always @(posedge clock) begin
      if (s_axi_rvalid && s_axi_rready)
         check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
   end
   // main sequence
   initial begin
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      rd(OFS_STAT, 34'h1);
      rd(OFS_SLOW, {2'h0, SLOW_RST});
      rd(OFS_FAST, {2'h0, FAST_RST});
      rd(8'h30, {RESP_SLVERR, 32'h0});
      wr(8'h30, 32'h1, RESP_SLVERR);
      rnd = xs(rnd);
      k = {27'h0, rnd[4:0]} + 32'h1;
      repeat (k) begin
         bstep <= 3'h1;
         @(posedge clock);
         bstep <= 3'h0;
         @(posedge clock);
      end
      axis_flag_set <= '1;
      @(posedge clock);
      axis_flag_set <= '0;
      wr(OFS_BASE, 32'h1, RESP_OKAY);
      wr(OFS_CTRL, 32'h8, RESP_OKAY);
      check({2'h0, axis_dem_pos[2*POS_W-1:POS_W]}, {2'h0, k});
      rd(OFS_FLAGS, {22'h0, ~FLAG_CLR_MASK});
      wr(OFS_BASE, 32'h0, RESP_OKAY);
      rd(OFS_FLAGS, {22'h0, ~FLAG_CLR_MASK});
      rnd = xs(rnd);
      f = {28'h1, rnd[2:0]};
      wr(OFS_FAST, f, RESP_OKAY);
      wr(OFS_CTRL, 32'h10, RESP_OKAY);
      repeat (3) tick();
      rd(OFS_DEMAND, {2'h0, 32'(3 * f)});
      feed_hold_input_n <= 1'b0;
      repeat (2) tick();
      rd(OFS_DEMAND, {2'h0, 32'(3 * f)});
      feed_hold_input_n <= 1'b1;
      positive_limit_input_n <= 1'b0;
      repeat (3) @(posedge clock);
      rd(OFS_STAT, 34'h5);
      positive_limit_input_n <= 1'b1;
      for (int c = 5; c < 7; c++) begin
         wr(OFS_CTRL, 32'h10, RESP_OKAY);
         wr(OFS_CTRL, 32'h1 << c, RESP_OKAY);
         rd(OFS_STAT, 34'h1);
      end
      foreach (hs[i]) home(hs[i]);
      wr(OFS_CTRL, 32'hF, RESP_OKAY);
      check({33'h0, homing_idle}, 34'h1);
      rnd = xs(rnd);
      v0 = 32'h1000 + {20'h0, rnd[11:0]};
      rnd = xs(rnd);
      v1 = rnd;
      wr(OFS_BASE, 32'h0, RESP_OKAY);
      wr(OFS_DEFINE_POSITION_CMD, v0, RESP_OKAY);
      wr(OFS_DEFINE_POSITION_CMD, v1, RESP_OKAY);
      rd(OFS_OFFSET, {2'h0, v0});
      check({2'h0, axis_dem_pos[2*POS_W-1:POS_W]}, {2'h0, k});
      tick();
      check({2'h0, axis_dem_pos[POS_W-1:0]}, {2'h0, v0});
      check({2'h0, axis_dem_pos[2*POS_W-1:POS_W]}, {2'h0, v1});
      rd(OFS_OFFSET, 34'h0);
      give_verdict();
   end
   // hang guard
   initial begin
      #2000000;
      failures++;
      give_verdict();
   end
endmodule
